// file: design/irg_pkg.sv
// package: register map, field layout and reset values of the request group
package irg_pkg;

  // ****************************************
  // register map
  // ****************************************
  // printed offset is not a multiple of four: it is the word index
  localparam logic [11:0] REQ_GROUP_IDX   = 12'hfc6;
  localparam logic [13:0] REQ_GROUP_ADDR  = {REQ_GROUP_IDX, 2'b00};
  localparam logic [13:0] IRQ_STATUS_ADDR = 14'h0000;
  localparam logic [13:0] IRQ_MASK_ADDR   = 14'h0004;
  localparam logic [13:0] GLOBAL_EN_ADDR  = 14'h0008;
  localparam logic [13:0] ACK_ADDR        = 14'h000c;

  // ****************************************
  // field layout
  // ****************************************
  localparam int REQ_WIDTH     = 8;
  localparam int BIT_RESERVED  = 7;
  localparam int BIT_MCT       = 6;
  localparam int BIT_SER_RX    = 5;
  localparam int BIT_SER_TX    = 4;
  localparam int BIT_PORTC_LO  = 0;
  localparam int PORTC_PINS    = 4;
  localparam int BIT_GLOBAL_EN = 0;
  localparam int EVT_WIDTH     = 2;
  localparam int EVT_VECTOR    = 0;
  localparam int EVT_LATCH_OFF = 1;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [7:0] REQ_GROUP_RESET = 8'h00;
  localparam logic [1:0] EVT_RESET       = 2'h0;
  localparam logic       GLOBAL_EN_RESET = 1'b0;

  typedef enum logic [2:0] {
    IRG_SEL_NONE,
    IRG_SEL_REQ,
    IRG_SEL_STAT,
    IRG_SEL_MASK,
    IRG_SEL_GEN,
    IRG_SEL_ACK
  } irg_sel_t;

endpackage : irg_pkg

// file: design/irg_flag_bit.sv
// one pending request flag with source set, software write and acknowledge
`timescale 1ns/1ps
`default_nettype none

module irg_flag_bit (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic srcReq,
  input  wire logic swWrite,
  input  wire logic swData,
  input  wire logic ackClr,
  output logic      flag
);

  logic flag_q;
  logic flag_d;

  // ****************************************
  // next value: a request wins over any clear
  // ****************************************
  assign flag_d = srcReq ? 1'b1 :
                  swWrite ? swData :
                  ackClr ? 1'b0 : flag_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end

  assign flag = flag_q;

endmodule : irg_flag_bit

`default_nettype wire

// file: design/irg_request_group.sv
// request group two: pending flags, vectored forward, avalon slave, interrupt
//
// How it works
// - a request from any source in the group sets that source's pending flag to one.
// - while global enable is on, any pending flag is forwarded to the core as a vectored request.
// - while global enable is off, flags still latch and the core can poll them over the bus.
// - bit six holds the multi-channel timer request.
// - bit five holds the second serial port receiver request.
// - bit four holds the second serial port transmitter request.
// - bits three to zero hold the port C pin requests, bit index equal to pin number.
`timescale 1ns/1ps
`default_nettype none

module irg_request_group #(
  parameter int PORTC_N = irg_pkg::PORTC_PINS
) (
  input  wire logic               clk,
  input  wire logic               rst_b,
  input  wire logic               multichannel_timer_request,
  input  wire logic               serial1_receive_request,
  input  wire logic               serial1_transmit_request,
  input  wire logic [PORTC_N-1:0] portc_pin_request,
  input  wire logic [7:0]         coreAck,
  output logic                    vectoredReq,
  output logic [7:0]              vectoredPending,
  input  wire logic [13:0]        address,
  input  wire logic               read,
  input  wire logic               write,
  input  wire logic [31:0]        writedata,
  input  wire logic [3:0]         byteenable,
  output logic [31:0]             readdata,
  output logic                    waitrequest,
  output logic                    response_err,
  output logic                    irq
);

  // ****************************************
  // bus decode
  // ****************************************
  logic       rdPending_q;
  logic       accept;
  logic       wrAccept;
  logic       lane0;
  logic       hitReq;
  logic       hitStat;
  logic       hitMask;
  logic       hitGen;
  logic       hitAck;
  irg_pkg::irg_sel_t sel;

  // read takes one wait cycle, write none
  assign waitrequest = read && !rdPending_q;
  assign accept      = (read && rdPending_q) || write;
  assign wrAccept    = write && lane0;
  assign lane0       = byteenable[0];
  assign hitReq      = address == irg_pkg::REQ_GROUP_ADDR;
  assign hitStat     = address == irg_pkg::IRQ_STATUS_ADDR;
  assign hitMask     = address == irg_pkg::IRQ_MASK_ADDR;
  assign hitGen      = address == irg_pkg::GLOBAL_EN_ADDR;
  assign hitAck      = address == irg_pkg::ACK_ADDR;
  assign sel = hitReq  ? irg_pkg::IRG_SEL_REQ  :
               hitStat ? irg_pkg::IRG_SEL_STAT :
               hitMask ? irg_pkg::IRG_SEL_MASK :
               hitGen  ? irg_pkg::IRG_SEL_GEN  :
               hitAck  ? irg_pkg::IRG_SEL_ACK  : irg_pkg::IRG_SEL_NONE;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdPending_q <= 1'b0;
    end else begin
      rdPending_q <= read && !rdPending_q;
    end
  end

  // ****************************************
  // source gathering
  // ****************************************
  logic [7:0] srcVec;
  logic [7:0] swWr;
  logic [7:0] ackVec;
  logic [7:0] flags;

  assign srcVec[irg_pkg::BIT_RESERVED]   = 1'b0;
  assign srcVec[irg_pkg::BIT_MCT]        = multichannel_timer_request;
  assign srcVec[irg_pkg::BIT_SER_RX]     = serial1_receive_request;
  assign srcVec[irg_pkg::BIT_SER_TX]     = serial1_transmit_request;
  assign srcVec[irg_pkg::BIT_PORTC_LO +: irg_pkg::PORTC_PINS] =
    portc_pin_request[irg_pkg::PORTC_PINS-1:0];

  logic reqWrite;
  logic ackWrite;
  assign reqWrite = wrAccept && (sel == irg_pkg::IRG_SEL_REQ);
  assign ackWrite = wrAccept && (sel == irg_pkg::IRG_SEL_ACK);
  assign swWr     = {8{reqWrite}};
  assign ackVec   = coreAck | (ackWrite ? writedata[7:0] : 8'h00);

  // ****************************************
  // pending flags
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < irg_pkg::BIT_RESERVED; gi++) begin : gFlag
      irg_flag_bit uFlag (
        .clk     (clk),
        .rst_b   (rst_b),
        .srcReq  (srcVec[gi]),
        .swWrite (swWr[gi]),
        .swData  (writedata[gi]),
        .ackClr  (ackVec[gi]),
        .flag    (flags[gi])
      );
    end
  endgenerate
  assign flags[irg_pkg::BIT_RESERVED] = 1'b0;

  // ****************************************
  // global enable and vectored forward
  // ****************************************
  logic globalEn_q;
  logic globalEn_d;
  assign globalEn_d = (wrAccept && sel == irg_pkg::IRG_SEL_GEN) ?
                      writedata[irg_pkg::BIT_GLOBAL_EN] : globalEn_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      globalEn_q <= irg_pkg::GLOBAL_EN_RESET;
    end else begin
      globalEn_q <= globalEn_d;
    end
  end

  logic [7:0] vecPend_q;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      vecPend_q <= irg_pkg::REQ_GROUP_RESET;
    end else begin
      vecPend_q <= globalEn_q ? flags : 8'h00;
    end
  end
  assign vectoredPending = vecPend_q;
  assign vectoredReq     = |vecPend_q;

  // ****************************************
  // event status and mask
  // ****************************************
  logic [1:0] evt;
  logic [1:0] stat_q;
  logic [1:0] stat_d;
  logic [1:0] mask_q;
  logic [1:0] mask_d;
  logic [1:0] w1c;
  logic       newReq;

  assign newReq = |(srcVec & ~flags);
  assign evt[irg_pkg::EVT_VECTOR]    = newReq && globalEn_q;
  assign evt[irg_pkg::EVT_LATCH_OFF] = newReq && !globalEn_q;
  assign w1c    = (wrAccept && sel == irg_pkg::IRG_SEL_STAT) ? writedata[1:0] : 2'b00;
  assign stat_d = evt | (stat_q & ~w1c);
  assign mask_d = (wrAccept && sel == irg_pkg::IRG_SEL_MASK) ? writedata[1:0] : mask_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stat_q <= irg_pkg::EVT_RESET;
      mask_q <= irg_pkg::EVT_RESET;
    end else begin
      stat_q <= stat_d;
      mask_q <= mask_d;
    end
  end
  assign irq = |(stat_q & mask_q);

  // ****************************************
  // read data
  // ****************************************
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic        err_q;
  logic        err_d;

  always_comb begin
    rdata_d = 32'h0;
    unique case (sel)
      irg_pkg::IRG_SEL_REQ:  rdata_d = {24'h0, flags};
      irg_pkg::IRG_SEL_STAT: rdata_d = {30'h0, stat_q};
      irg_pkg::IRG_SEL_MASK: rdata_d = {30'h0, mask_q};
      irg_pkg::IRG_SEL_GEN:  rdata_d = {31'h0, globalEn_q};
      irg_pkg::IRG_SEL_ACK:  rdata_d = 32'h0;
      irg_pkg::IRG_SEL_NONE: rdata_d = 32'h0;
    endcase
  end
  assign err_d = accept && (sel == irg_pkg::IRG_SEL_NONE);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_q <= 32'h0;
      err_q   <= 1'b0;
    end else begin
      rdata_q <= (read && !rdPending_q) ? rdata_d : rdata_q;
      err_q   <= err_d;
    end
  end
  assign readdata     = rdata_q;
  assign response_err = err_q;

endmodule : irg_request_group

`default_nettype wire

// file: tb/irg_core_model.sv
// core model: acknowledges vectored requests after a chosen latency
`timescale 1ns/1ps
`default_nettype none
module irg_core_model (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic [3:0] lat,
  input  wire logic       vectoredReq,
  input  wire logic [7:0] vectoredPending,
  output logic [7:0]      coreAck
);
  logic [3:0] waitCnt_q;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      waitCnt_q <= 4'h0;
      coreAck   <= 8'h00;
    end else begin
      coreAck <= 8'h00;
      if (!vectoredReq) waitCnt_q <= 4'h0;
      else if (waitCnt_q == lat) begin
        coreAck   <= vectoredPending;
        waitCnt_q <= 4'h0;
      end else waitCnt_q <= waitCnt_q + 4'h1;
    end
  end
endmodule : irg_core_model
`default_nettype wire

// file: tb/irg_request_group_sva.sv
// checker: bus timing, forwarding and clearing of request flags
`timescale 1ns/1ps
`default_nettype none
module irg_request_group_sva #(parameter int PORTC_N = 4) (
  input wire logic               clk,
  input wire logic               rst_b,
  input wire logic               multichannel_timer_request,
  input wire logic               serial1_receive_request,
  input wire logic               serial1_transmit_request,
  input wire logic [PORTC_N-1:0] portc_pin_request,
  input wire logic [7:0]         coreAck,
  input wire logic               vectoredReq,
  input wire logic [7:0]         vectoredPending,
  input wire logic [13:0]        address,
  input wire logic               read,
  input wire logic               write,
  input wire logic [31:0]        readdata,
  input wire logic               waitrequest,
  input wire logic               response_err
);
  wire [7:0] s = 8'({multichannel_timer_request, serial1_receive_request, serial1_transmit_request,
    portc_pin_request});
  wire unm = !(address inside {irg_pkg::REQ_GROUP_ADDR, irg_pkg::IRQ_STATUS_ADDR, irg_pkg::IRQ_MASK_ADDR,
    irg_pkg::GLOBAL_EN_ADDR, irg_pkg::ACK_ADDR});
  wire acc = write || (read && !waitrequest);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_vec_any: assert property (vectoredReq == |vectoredPending)
    else $error("vectored request and pending flags disagree");
  a_rd_wait: assert property (read && waitrequest |=> read && !waitrequest) else $error("read answer late");
  a_wr_nowait: assert property (write |-> !waitrequest) else $error("write stalled");
  a_src_fwd: assert property ((vectoredPending != 0 && !write && !$past(write)) ##1 !write
    |=> (vectoredPending & $past(s, 2)) == $past(s, 2)) else $error("request not forwarded");
  a_rd_bit7: assert property (read && !waitrequest && address == irg_pkg::REQ_GROUP_ADDR |-> !readdata[7])
    else $error("reserved bit reads one");
  a_unmap_err: assert property (acc && unm |=> response_err) else $error("no error response");
  a_unmap_zero: assert property (read && !waitrequest && unm |-> readdata == 0) else $error("unmapped read not zero");
  a_ack_clear: assert property (!write |-> ##2 (vectoredPending & $past(coreAck & ~s, 2)) == 0)
    else $error("flag not cleared by acknowledge");
endmodule : irg_request_group_sva
bind irg_request_group irg_request_group_sva #(.PORTC_N(PORTC_N)) irg_request_group_sva_inst (
  .clk                        (clk),
  .rst_b                      (rst_b),
  .multichannel_timer_request (multichannel_timer_request),
  .serial1_receive_request    (serial1_receive_request),
  .serial1_transmit_request   (serial1_transmit_request),
  .portc_pin_request          (portc_pin_request),
  .coreAck                    (coreAck),
  .vectoredReq                (vectoredReq),
  .vectoredPending            (vectoredPending),
  .address                    (address),
  .read                       (read),
  .write                      (write),
  .readdata                   (readdata),
  .waitrequest                (waitrequest),
  .response_err               (response_err)
);
`default_nettype wire

// file: tb/irg_request_group_tb.sv
// testbench: request group registers, sources, core acknowledge
`timescale 1ns/1ps
`default_nettype none
module irg_request_group_tb;
  logic        clk = 1'b0, rst_b = 1'b0, read = 1'b0, write = 1'b0, vectoredReq, waitrequest, response_err, irq;
  logic [6:0]  srcV = 7'h00, r;
  logic [13:0] address = 14'h0000;
  logic [31:0] writedata = 32'h0, readdata, expQ[$];
  logic [3:0]  byteenable = 4'hf, lat = 4'h1;
  logic [7:0]  coreAck, vectoredPending;
  int          n_mismatch = 0, compares = 0;
  irg_request_group irg_request_group_inst (.clk(clk), .rst_b(rst_b), .multichannel_timer_request(srcV[6]),
    .serial1_receive_request(srcV[5]), .serial1_transmit_request(srcV[4]), .portc_pin_request(srcV[3:0]),
    .coreAck(coreAck), .vectoredReq(vectoredReq), .vectoredPending(vectoredPending), .address(address),
    .read(read), .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .response_err(response_err), .irq(irq));
  irg_core_model irg_core_model_inst (.clk(clk), .rst_b(rst_b), .lat(lat), .vectoredReq(vectoredReq),
    .vectoredPending(vectoredPending), .coreAck(coreAck));
  initial forever #2 clk = ~clk;
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] e);
    compares++;
    if (seen !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, seen);
    end
  endtask : chk
  task automatic test_done;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : test_done
  task automatic acc(input logic w, input logic [13:0] a, input logic [31:0] d, input logic [31:0] e);
    int n;
    if (!w) expQ.push_back(e);
    address <= a;
    writedata <= d;
    write <= w;
    read <= !w;
    n = 0;
    do begin @(posedge clk); n++; end while (waitrequest !== 1'b0 && n < 20);
    if (waitrequest !== 1'b0) begin n_mismatch++; test_done(); end
    read <= 1'b0;
    write <= 1'b0;
    byteenable <= 4'hf;
    @(posedge clk);
  endtask : acc
  task automatic pulse(input logic [6:0] v);
    srcV <= v;
    @(posedge clk);
    srcV <= 7'h00;
    repeat (2) @(posedge clk);
  endtask : pulse
  always @(posedge clk)
    if (read === 1'b1 && waitrequest === 1'b0) chk("readdata", readdata, expQ.pop_front());
  initial begin
    void'($urandom(36212));
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    for (int a = 0; a < 16; a += 4) acc(0, 14'(a), 0, 0);
    acc(0, irg_pkg::REQ_GROUP_ADDR, 0, 0);
    for (int i = 0; i < 7; i++) begin
      pulse(7'h01 << i);
      chk("vectoredPending", 32'(vectoredPending), 0);
      acc(0, irg_pkg::REQ_GROUP_ADDR, 0, (32'h2 << i) - 32'h1);
    end
    acc(1, irg_pkg::ACK_ADDR, 32'hff, 0);
    acc(0, irg_pkg::REQ_GROUP_ADDR, 0, 0);
    byteenable <= 4'h0;
    acc(1, irg_pkg::REQ_GROUP_ADDR, 32'h0f, 0);
    acc(0, irg_pkg::REQ_GROUP_ADDR, 0, 0);
    acc(1, irg_pkg::REQ_GROUP_ADDR, 32'h7f, 0);
    acc(0, irg_pkg::REQ_GROUP_ADDR, 0, 32'h7f);
    acc(1, irg_pkg::REQ_GROUP_ADDR, 0, 0);
    acc(0, irg_pkg::REQ_GROUP_ADDR, 0, 0);
    chk("irq", 32'(irq), 0);
    acc(1, irg_pkg::IRQ_MASK_ADDR, 32'h2, 0);
    chk("irq", 32'(irq), 1);
    acc(1, irg_pkg::IRQ_STATUS_ADDR, 32'h2, 0);
    chk("irq", 32'(irq), 0);
    acc(0, irg_pkg::IRQ_STATUS_ADDR, 0, 0);
    acc(1, irg_pkg::GLOBAL_EN_ADDR, 32'h1, 0);
    lat <= 4'($urandom_range(15, 1));
    r = 7'($urandom_range(127, 1));
    pulse(r);
    chk("vectoredPending", 32'(vectoredPending), 32'(r));
    chk("vectoredReq", 32'(vectoredReq), 1);
    pulse(7'($urandom_range(127, 1)));
    for (int n = 0; n < 40 && vectoredReq !== 1'b0; n++) @(posedge clk);
    chk("vectoredReq", 32'(vectoredReq), 0);
    if (vectoredReq !== 1'b0) test_done();
    acc(0, irg_pkg::REQ_GROUP_ADDR, 0, 0);
    acc(0, irg_pkg::IRQ_STATUS_ADDR, 0, 32'h1);
    acc(1, irg_pkg::REQ_GROUP_ADDR, 32'h55, 0);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    acc(0, irg_pkg::REQ_GROUP_ADDR, 0, 0);
    acc(0, irg_pkg::GLOBAL_EN_ADDR, 0, 0);
    acc(1, 14'h0010, 32'hff, 0);
    chk("response_err", 32'(response_err), 1);
    acc(0, 14'h0010, 0, 0);
    chk("response_err", 32'(response_err), 1);
    test_done();
  end
endmodule : irg_request_group_tb
`default_nettype wire
